// file: core/adc_output_port.sv
// digital output side of a pipelined converter: latency line, buffer, pins
module adc_output_port #(
  parameter int WIDTH   = adc_port_pkg::CODE_WIDTH,
  parameter int LATENCY = adc_port_pkg::LATENCY_CYCLES
) (
  input  wire logic             CLOCK,
  input  wire logic             RST,
  input  wire logic [WIDTH-1:0] SAMPLE_IN,
  input  wire logic             OUT_ENABLE_N,
  input  wire logic             SHUTDOWN_REQUEST,
  input  wire logic             OUT_READY,
  output logic [WIDTH-1:0]      SAMPLE_CODE_BITS,
  output logic [WIDTH-1:0]      SAMPLE_CODE_OE,
  output logic                  OUT_VALID
);
  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  if (WIDTH != adc_port_pkg::CODE_WIDTH) begin : g_bad_width
    $error("code width must be twelve");
  end
  if (LATENCY < 3) begin : g_bad_lat
    $error("latency must be at least three");
  end

  localparam int LINE = LATENCY - 2;

  // ----------------------------------------------------------------------
  // sample pipeline
  // ----------------------------------------------------------------------
  // two stages of the latency sit in the buffer and the pin register,
  // so the line carries the rest; a stalled receiver breaks the figure.
  adc_port_pkg::sample_t line_q [LINE];
  logic                  run;

  assign run = ~SHUTDOWN_REQUEST;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < LINE; i++) begin
        line_q[i] <= '0;
      end
    end else if (run) begin
      line_q[0] <= '{valid: 1'b1, code: SAMPLE_IN};
      for (int i = 1; i < LINE; i++) begin
        line_q[i] <= line_q[i-1];
      end
    end
  end

  // ----------------------------------------------------------------------
  // two-entry buffer
  // ----------------------------------------------------------------------
  logic [WIDTH-1:0] buf_q [adc_port_pkg::BUF_DEPTH];
  logic [1:0]       cnt_q;
  logic             push;
  logic             pop;
  logic             buf_ready;
  logic             pin_load;

  assign buf_ready = (cnt_q != 2'h2);
  assign push      = run & line_q[LINE-1].valid & buf_ready;
  assign pin_load  = run & (~OUT_VALID | OUT_READY);
  assign pop       = pin_load & (cnt_q != 2'h0);

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      cnt_q     <= 2'h0;
      buf_q[0]  <= adc_port_pkg::CODE_RESET;
      buf_q[1]  <= adc_port_pkg::CODE_RESET;
    end else begin
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      if (pop) begin
        buf_q[0] <= buf_q[1];
      end
      if (push) begin
        if (pop) begin
          buf_q[cnt_q == 2'h2 ? 1 : (cnt_q == 2'h1 ? 0 : 0)] <=
            line_q[LINE-1].code;
        end else begin
          buf_q[cnt_q[0]] <= line_q[LINE-1].code;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // pin register
  // ----------------------------------------------------------------------
  // during shutdown pin_load stays low, so the last word is held
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      SAMPLE_CODE_BITS <= adc_port_pkg::CODE_RESET;
      OUT_VALID        <= 1'b0;
    end else if (pin_load) begin
      if (cnt_q != 2'h0) begin
        SAMPLE_CODE_BITS <= buf_q[0];
        OUT_VALID        <= 1'b1;
      end else begin
        OUT_VALID <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      SAMPLE_CODE_OE <= '0;
    end else begin
      SAMPLE_CODE_OE <= {WIDTH{~OUT_ENABLE_N}};
    end
  end
endmodule

// file: dv/adc_port_assertions.sv
// assertions for the converter output port
module adc_port_checker #(parameter int LATENCY = 7) (
  input wire logic        CLOCK, RST, OUT_ENABLE_N, OUT_READY,
  input wire logic        SHUTDOWN_REQUEST, OUT_VALID,
  input wire logic [11:0] SAMPLE_IN, SAMPLE_CODE_BITS, SAMPLE_CODE_OE);
  logic [3:0] n_q;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  // a stall or freeze shifts the latency of the words in flight, so exact checks stop for good
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) n_q <= 4'h0;
    else if (!OUT_READY || SHUTDOWN_REQUEST) n_q <= 4'hf;
    else n_q <= n_q + {3'h0, n_q < LATENCY};
  end
  property p_oe; 1 |=> SAMPLE_CODE_OE == {12{!$past(OUT_ENABLE_N)}};
  endproperty
  a_oe: assert property (p_oe) else $error("enable");
  property p_hold; SHUTDOWN_REQUEST |=> $stable(SAMPLE_CODE_BITS); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_lat; n_q == LATENCY |-> SAMPLE_CODE_BITS ==
    $past(SAMPLE_IN, LATENCY); endproperty
  a_lat: assert property (p_lat) else $error("code");
  property p_early; n_q < LATENCY |-> !OUT_VALID; endproperty
  a_early: assert property (p_early) else $error("early");
  property p_stand; OUT_VALID && !OUT_READY |=>
    OUT_VALID && $stable(SAMPLE_CODE_BITS); endproperty
  a_stand: assert property (p_stand) else $error("stand");
  property p_float; OUT_ENABLE_N |=> SAMPLE_CODE_OE == 12'h000; endproperty
  a_float: assert property (p_float) else $error("float");
  c_stall: cover property (OUT_VALID && !OUT_READY);
  c_freeze: cover property (SHUTDOWN_REQUEST && OUT_VALID);
  c_float: cover property (OUT_ENABLE_N);
endmodule
bind adc_output_port adc_port_checker #(.LATENCY(LATENCY))
  adc_port_checker_i (.*);

// file: dv/capture_model.sv
// far side: capture logic that stalls at random
module capture_model (
  input wire logic        clk, stall,
  input wire logic [11:0] bits, oe,
  output logic            ready = 1'b1,
  output logic [11:0]     pins);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clk) ready <= #1 !(stall && $urandom_range(1));
  // a floating pin reads the inverse, so a stale word never passes
  assign pins = oe & bits | ~oe & ~bits;
endmodule

// file: dv/testbench.sv
// self-checking bench for the converter output port
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, oen = 0, sd = 0, stall = 0, rdy, vld;
  logic [11:0] sin = 12'h000, bits, oe, pins, h[90];
  int n_errors = 0, n_checks = 0;
  always #20 clk = ~clk;
  adc_output_port adc_output_port_i (.CLOCK(clk), .RST(rst), .SAMPLE_IN(sin),
    .OUT_ENABLE_N(oen), .SHUTDOWN_REQUEST(sd), .OUT_READY(rdy),
    .SAMPLE_CODE_BITS(bits), .SAMPLE_CODE_OE(oe), .OUT_VALID(vld));
  capture_model capture_model_i (.clk(clk), .stall(stall), .bits(bits),
    .oe(oe), .ready(rdy), .pins(pins));
  task chk(string s, logic [11:0] seen, logic [11:0] exp);
    n_checks++;
    n_errors += int'(seen !== exp);
    if (seen !== exp) $display("Error %s expected %h seen %h", s, exp, seen);
  endtask
  task end_sim;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(37959));
    repeat (2) @(posedge clk);
    #1 rst = 0;
    for (int j = 0; j < 90; j++) begin
      if (j > 6 && j < 50) chk("code", pins, h[j-7]);
      if (j > 50 && j < 56) chk("hold", bits, h[43]);
      if (j > 0) chk("enable", oe, {12{~oen}});
      if (j > 0 && j < 50) chk("valid", {11'h000, vld}, {11'h000, j > 6});
      if (j % 30 == 29) $display("test %0d done", j / 30);
      h[j] = j < 13 ? {j > 10, {11{j == 11}}} : 12'($urandom);
      sin = h[j];
      {sd, oen, stall} = {j >= 50 && j < 55, j > 55 && j < 60, j >= 60};
      @(posedge clk) #1;
    end
    end_sim;
  end
endmodule

// file: inc/adc_port_pkg.sv
// constants and carrier types for the pipelined converter output port
// ----------------------------------------------------------------------
// Overview of operation
// - the twelve data pins float whenever the active-low output enable is high.
// - with outputs enabled and shutdown requested, the last word before shutdown keeps being driven unchanged.
// - each result reaches the data pins exactly seven clock cycles after the edge that took its sample; with OUT_READY low the code delays or drops words.
// - a sample is taken on the rising edge of the true conversion clock.
// - each result is a 12-bit parallel word with bit 0 the lsb and bit 11 the msb.
// - results are offset binary, zero input giving 800, full positive fff and full negative 000.
// - a high shutdown request stops normal conversion.
// - a low output enable makes the device drive the data pins actively.
// ----------------------------------------------------------------------
package adc_port_pkg;
  localparam int          CODE_WIDTH     = 12;
  localparam int          LATENCY_CYCLES = 7;
  localparam logic [11:0] CODE_ZERO      = 12'h800;
  localparam logic [11:0] CODE_RESET     = 12'h800;
  localparam int          BUF_DEPTH      = 2;

  typedef struct packed {
    logic        valid;
    logic [11:0] code;
  } sample_t;
endpackage
